/* include/ecr_regs.vh */
// register addresses, field positions and reset values of the configuration readout
`ifndef ECR_REGS_VH
`define ECR_REGS_VH
`define ECR_SIG_ADDR0 16'hFC30
`define ECR_SIG_ADDR1 16'hFC31
`define ECR_SIG_ADDR2 16'hFC60
`define ECR_CUST_BASE 16'hFCE0
`define ECR_CUST_LAST 16'hFCFF
`define ECR_CFG1_ADDR 16'hFD00
`define ECR_CFG2_ADDR 16'hFD01
`define ECR_CFG_RESET 8'hFF
`define ECR_BIT_WDT 7
`define ECR_BIT_PIN_OFF 6
`define ECR_BIT_PRL 5
`define ECR_BIT_BROWNOUT 4
`define ECR_BIT_RATE 3
`define ECR_OSC_HI 2
`define ECR_OSC_LO 0
`define ECR_OSC_EXT 3'h7
`define ECR_OSC_RC 3'h3
`define ECR_OSC_LF 3'h2
`define ECR_OSC_MF 3'h1
`define ECR_OSC_HF 3'h0
`define ECR_SRC_EXT 3'h0
`define ECR_SRC_RC 3'h1
`define ECR_SRC_LF 3'h2
`define ECR_SRC_MF 3'h3
`define ECR_SRC_HF 3'h4
`define ECR_SRC_RSV 3'h5
`define ECR_CUST_IDX_W 5
`define ECR_CUST_BYTES 32
`define ECR_PIN_IDLE 4'hF
`define ECR_ZERO8 8'h00
`endif

/* logic/ecr_sync2.v */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module ecr_sync2 #(
    parameter W = 1
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] d_i,
    input wire [W-1:0] rst_val_i,
    output reg [W-1:0] q_o
);
reg [W-1:0] meta_r;
always @(posedge clk_i) begin
    if (rst_i) begin
        meta_r <= rst_val_i;
        q_o <= rst_val_i;
    end else begin
        meta_r <= d_i;
        q_o <= meta_r;
    end
end
endmodule

/* logic/ecr_top.v */
// configuration and identification readout with power-up latch of configuration bytes one and two
// Operation
// R1 - programmer exchanges commands, addresses, data serially on two pins in programming mode
// R2 - three signature bytes readable by programmer and by CPU code reads
// R3 - customer area FCE0h..FCFFh returns stored bytes on code-space reads
// R4 - no instruction fetch from customer area; data reads only (code serves the area on code reads only, data reads miss)
// R5 - configuration effect fixed at power-up; software cannot change it
// R6 - programmer writes configuration bytes like main program memory
// R7 - configuration bytes readable by data-space reads, byte one at FD00
// R8 - watchdog enable bit 0 disables watchdog reset; timer interrupt stays
// R9 - reset pin disable bit 1 makes shared pin a plain input
// R10 - port reset level bit selects high or low port state in reset
// R11 - programmer always programs brownout bit to zero
// R12 - oscillator field selects external, RC, low, medium or high source
// R13 - cycle clock rate bit presented as static output to clock logic
`timescale 1ns/10ps
`include "ecr_regs.vh"
module ecr_top #(
    parameter SIG0 = 8'h15,
    parameter SIG1 = 8'hA5,
    parameter SIG2 = 8'h3C
) (
    input wire SYS_CLK_I,
    input wire RST_I,
    input wire [7:0] NV_CFG1_I,
    input wire [7:0] NV_CFG2_I,
    input wire [255:0] NV_CUST_I,
    input wire CODE_RD_I,
    input wire DATA_RD_I,
    input wire [15:0] DATA_POINTER_I,
    input wire SHARED_RESET_PIN_I,
    input wire PROG_MODE_I,
    input wire PROG_SCLK_I,
    input wire PROG_SDA_I,
    output reg [7:0] RD_DATA_O,
    output reg RD_VALID_O,
    output reg RD_HIT_O,
    output reg WATCHDOG_RESET_EN_O,
    output reg PIN_RESET_O,
    output reg PIN_INPUT_O,
    output reg PORT_RESET_LEVEL_O,
    output reg CYCLE_CLOCK_RATE_O,
    output reg [2:0] OSC_SOURCE_O,
    output reg OSC_FIELD_VALID_O,
    output reg PROG_SCLK_O,
    output reg PROG_SDA_O,
    output reg CFG_LOADED_O
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
// pins come from outside the clock domain, two flops before any use
wire [3:0] pins_s;
ecr_sync2 #(.W(4)) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .d_i({SHARED_RESET_PIN_I, PROG_MODE_I, PROG_SCLK_I, PROG_SDA_I}),
    .rst_val_i(`ECR_PIN_IDLE),
    .q_o(pins_s)
);

// ----------------------------------------------------------------
// power-up latch
// ----------------------------------------------------------------
// captured once after reset release; later nv changes are ignored
// nv cells are settled long before reset drops, so one sample suffices
reg loaded_r;
reg [7:0] cfg1_r;
reg [7:0] cfg2_r;
always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
        loaded_r <= 1'b0;
        cfg1_r <= `ECR_CFG_RESET;
        cfg2_r <= `ECR_CFG_RESET;
    end else if (!loaded_r) begin
        // R5 latch once only
        loaded_r <= 1'b1;
        cfg1_r <= NV_CFG1_I;
        cfg2_r <= NV_CFG2_I;
    end
end

// ----------------------------------------------------------------
// oscillator decode
// ----------------------------------------------------------------
reg [2:0] osc_nxt;
reg osc_ok_nxt;
always @* begin
    osc_ok_nxt = 1'b1;
    // R12 source select
    case (cfg1_r[`ECR_OSC_HI:`ECR_OSC_LO])
        `ECR_OSC_EXT: osc_nxt = `ECR_SRC_EXT;
        `ECR_OSC_RC: osc_nxt = `ECR_SRC_RC;
        `ECR_OSC_LF: osc_nxt = `ECR_SRC_LF;
        `ECR_OSC_MF: osc_nxt = `ECR_SRC_MF;
        `ECR_OSC_HF: osc_nxt = `ECR_SRC_HF;
        default: begin
            // reserved codes get their own source code and are flagged invalid
            osc_nxt = `ECR_SRC_RSV;
            osc_ok_nxt = 1'b0;
        end
    endcase
end

// ----------------------------------------------------------------
// static configuration outputs
// ----------------------------------------------------------------
// in reset the outputs show the unprogrammed byte, the safest view
localparam [7:0] cfg_unprog = `ECR_CFG_RESET;
always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
        WATCHDOG_RESET_EN_O <= cfg_unprog[`ECR_BIT_WDT];
        PIN_RESET_O <= 1'b0;
        PIN_INPUT_O <= 1'b1;
        PORT_RESET_LEVEL_O <= cfg_unprog[`ECR_BIT_PRL];
        CYCLE_CLOCK_RATE_O <= cfg_unprog[`ECR_BIT_RATE];
        OSC_SOURCE_O <= `ECR_SRC_EXT;
        OSC_FIELD_VALID_O <= 1'b1;
        CFG_LOADED_O <= 1'b0;
    end else begin
        // R8 programmed zero kills watchdog reset only
        WATCHDOG_RESET_EN_O <= cfg1_r[`ECR_BIT_WDT];
        // R9 pin reset function gated off
        PIN_RESET_O <= ~cfg1_r[`ECR_BIT_PIN_OFF] & ~pins_s[3];
        // pin level is always visible, whatever its reset role
        PIN_INPUT_O <= pins_s[3];
        // R10 port level in reset
        PORT_RESET_LEVEL_O <= cfg1_r[`ECR_BIT_PRL];
        // R13 static rate bit
        CYCLE_CLOCK_RATE_O <= cfg1_r[`ECR_BIT_RATE];
        OSC_SOURCE_O <= osc_nxt;
        OSC_FIELD_VALID_O <= osc_ok_nxt;
        CFG_LOADED_O <= loaded_r;
    end
end

// ----------------------------------------------------------------
// cpu read port
// ----------------------------------------------------------------
// one flag per mapped address, and one range flag for the customer area, keeps the read mux flat
wire at_sig0 = (DATA_POINTER_I == `ECR_SIG_ADDR0);
wire at_sig1 = (DATA_POINTER_I == `ECR_SIG_ADDR1);
wire at_sig2 = (DATA_POINTER_I == `ECR_SIG_ADDR2);
wire at_cfg1 = (DATA_POINTER_I == `ECR_CFG1_ADDR);
wire at_cfg2 = (DATA_POINTER_I == `ECR_CFG2_ADDR);
wire in_cust = (DATA_POINTER_I >= `ECR_CUST_BASE) && (DATA_POINTER_I <= `ECR_CUST_LAST);
wire [`ECR_CUST_IDX_W-1:0] cust_idx = DATA_POINTER_I[`ECR_CUST_IDX_W-1:0];

// ----------------------------------------------------------------
// customer area byte lanes
// ----------------------------------------------------------------
// area base is aligned to its size, so the low pointer bits pick the lane
wire [7:0] cust_mem [0:`ECR_CUST_BYTES-1];
genvar gi;
generate
    for (gi = 0; gi < `ECR_CUST_BYTES; gi = gi + 1) begin : g_cust
        assign cust_mem[gi] = NV_CUST_I[8*gi+7:8*gi];
    end
endgenerate
wire [7:0] cust_byte = cust_mem[cust_idx];

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
reg [7:0] rd_nxt;
reg hit_nxt;
always @* begin
    rd_nxt = `ECR_ZERO8;
    hit_nxt = 1'b0;
    if (CODE_RD_I) begin
        hit_nxt = 1'b1;
        // R2 signature bytes via code reads
        if (at_sig0)
            rd_nxt = SIG0;
        else if (at_sig1)
            rd_nxt = SIG1;
        else if (at_sig2)
            rd_nxt = SIG2;
        // R3 customer area
        else if (in_cust)
            rd_nxt = cust_byte;
        else
            hit_nxt = 1'b0;
    end else if (DATA_RD_I) begin
        hit_nxt = 1'b1;
        // R7 config bytes via data reads
        if (at_cfg1)
            rd_nxt = cfg1_r;
        else if (at_cfg2)
            rd_nxt = cfg2_r;
        else
            hit_nxt = 1'b0;
    end
end

// R4 read-only data path, no fetch port here
always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
        RD_DATA_O <= `ECR_ZERO8;
        RD_VALID_O <= 1'b0;
        RD_HIT_O <= 1'b0;
    end else begin
        RD_DATA_O <= rd_nxt;
        RD_VALID_O <= CODE_RD_I | DATA_RD_I;
        RD_HIT_O <= hit_nxt;
    end
end

// ----------------------------------------------------------------
// programming pins
// ----------------------------------------------------------------
// R1 serial pins pass to the programming engine outside this block
// gated by mode so stray pin activity in normal running stays inside
always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
        PROG_SCLK_O <= 1'b0;
        PROG_SDA_O <= 1'b0;
    end else begin
        PROG_SCLK_O <= pins_s[2] & pins_s[1];
        PROG_SDA_O <= pins_s[2] & pins_s[0];
    end
end

endmodule

/* dv/ecr_prog_model.sv */
// programmed eprom content left behind by the serial programmer
`timescale 1ns/10ps
module ecr_prog_model (
    input wire logic [7:0] cfg1_i,
    output logic [7:0] nv_cfg1_o,
    output logic [255:0] nv_cust_o
);
    // written like code space, brownout bit always zero
    assign nv_cfg1_o = cfg1_i & 8'hEF;
    // customer byte i holds 40h plus i
    for (genvar i = 0; i < 32; i++) begin : g_byte
        assign nv_cust_o[8*i+:8] = 8'h40 + 8'(i);
    end
endmodule

/* dv/ecr_checker.sv */
// port assertions of the configuration readout
`timescale 1ns/10ps
module ecr_checker (
    input wire SYS_CLK_I,
    input wire RST_I,
    input wire CODE_RD_I,
    input wire DATA_RD_I,
    input wire [15:0] DATA_POINTER_I,
    input wire [7:0] NV_CFG1_I,
    input wire [7:0] RD_DATA_O,
    input wire RD_VALID_O,
    input wire RD_HIT_O,
    input wire WATCHDOG_RESET_EN_O,
    input wire PORT_RESET_LEVEL_O,
    input wire CYCLE_CLOCK_RATE_O,
    input wire [2:0] OSC_SOURCE_O,
    input wire OSC_FIELD_VALID_O,
    input wire CFG_LOADED_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    wire rd = CODE_RD_I | DATA_RD_I;
    sequence s_release;
        $fell(RST_I);
    endsequence
    sequence s_load;
        !CFG_LOADED_O ##1 !CFG_LOADED_O ##1 CFG_LOADED_O;
    endsequence
    chk_read_answer: assert property (rd |=> RD_VALID_O)
        else $error("read not answered");
    chk_no_stray: assert property (!rd |=> !RD_VALID_O)
        else $error("answer without read");
    chk_cfg_view: assert property (CFG_LOADED_O && DATA_RD_I && !CODE_RD_I && DATA_POINTER_I == 16'hFD00
        |=> RD_HIT_O && RD_DATA_O[7] == WATCHDOG_RESET_EN_O && RD_DATA_O[3] == CYCLE_CLOCK_RATE_O)
        else $error("config read differs from applied value");
    chk_code_cfg: assert property (CODE_RD_I && DATA_POINTER_I == 16'hFD00 |=> !RD_HIT_O && RD_DATA_O == 8'h00)
        else $error("code read of config byte hit");
    chk_cust_data: assert property (!CODE_RD_I && DATA_RD_I && DATA_POINTER_I[15:5] == 11'h7E7 |=> !RD_HIT_O)
        else $error("data read of customer area hit");
    chk_cfg_static: assert property (CFG_LOADED_O && $past(CFG_LOADED_O)
        |-> $stable({WATCHDOG_RESET_EN_O, PORT_RESET_LEVEL_O, CYCLE_CLOCK_RATE_O, OSC_SOURCE_O}))
        else $error("config output moved after load");
    chk_osc_valid: assert property (CFG_LOADED_O |-> OSC_FIELD_VALID_O == (OSC_SOURCE_O != 3'h5))
        else $error("osc valid flag wrong");
    chk_load_seq: assert property (s_release |-> s_load)
        else $error("config load timing wrong");
    chk_wd_latch: assert property (s_release ##2 1'b1 |-> WATCHDOG_RESET_EN_O == $past(NV_CFG1_I[7], 2))
        else $error("watchdog enable not latched");
endmodule
bind ecr_top ecr_checker ecr_checker_i (.*);

/* dv/ecr_top_tb_top.sv */
// self-checking bench of the configuration readout
`timescale 1ns/10ps
module ecr_top_tb_top;
    // arbitrary signature values
    localparam logic [7:0] S0 = 8'h15, S1 = 8'h6B, S2 = 8'h2D;
    localparam logic [3:0] OSC_EXP [0:7] = '{4'hC, 4'hB, 4'hA, 4'h9, 4'h5, 4'h5, 4'h5, 4'h8};
    logic clk = 0, rst = 1, crd = 0, drd = 0, pin = 1, pm = 0, psc = 0, psd = 0;
    logic [15:0] dp = 16'h0000;
    logic [7:0] cfg = 8'hFF, nv1, rdd;
    logic [255:0] cust;
    logic rv, rh, wd, prst, pinp, prl, ckr, ov, loaded, sclo, sdao;
    logic [2:0] osc;
    int error_cnt = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    ecr_prog_model ecr_prog_model_i (.cfg1_i(cfg), .nv_cfg1_o(nv1), .nv_cust_o(cust));
    ecr_top #(.SIG0(S0), .SIG1(S1), .SIG2(S2)) ecr_top_i (.SYS_CLK_I(clk), .RST_I(rst), .NV_CFG1_I(nv1),
        .NV_CFG2_I(~cfg), .NV_CUST_I(cust), .CODE_RD_I(crd), .DATA_RD_I(drd), .DATA_POINTER_I(dp),
        .SHARED_RESET_PIN_I(pin), .PROG_MODE_I(pm), .PROG_SCLK_I(psc), .PROG_SDA_I(psd), .RD_DATA_O(rdd),
        .RD_VALID_O(rv), .RD_HIT_O(rh), .WATCHDOG_RESET_EN_O(wd), .PIN_RESET_O(prst), .PIN_INPUT_O(pinp),
        .PORT_RESET_LEVEL_O(prl), .CYCLE_CLOCK_RATE_O(ckr), .OSC_SOURCE_O(osc), .OSC_FIELD_VALID_O(ov),
        .PROG_SCLK_O(sclo), .PROG_SDA_O(sdao), .CFG_LOADED_O(loaded));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // nv content is only sampled once after release
    task automatic boot(input logic [7:0] c);
        @(posedge clk);
        rst <= 1;
        cfg <= c;
        repeat (6) @(posedge clk);
        rst <= 0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic code, input logic [15:0] a, input logic [7:0] ed, input logic eh);
        @(posedge clk);
        crd <= code;
        drd <= !code;
        dp <= a;
        @(posedge clk);
        crd <= 0;
        drd <= 0;
        #1;
        chk({6'h0, rv, rh}, {7'h1, eh});
        chk(rdd, ed);
    endtask
    task automatic t_reads;
        boot(8'hFF);
        rd(1, 16'hFC30, S0, 1);
        rd(1, 16'hFC31, S1, 1);
        rd(1, 16'hFC60, S2, 1);
        rd(1, 16'hFCE0, 8'h40, 1);
        rd(1, 16'hFCFF, 8'h5F, 1);
        rd(0, 16'hFCE5, 8'h00, 0);
        rd(1, 16'hFD00, 8'h00, 0);
    endtask
    task automatic t_cfg(input logic [7:0] c, input logic [7:0] e);
        boot(c);
        chk({5'h0, wd, prl, ckr}, e);
        rd(0, 16'hFD00, c & 8'hEF, 1);
        rd(0, 16'hFD01, ~c, 1);
        @(posedge clk);
        cfg <= ~c;
        repeat (4) @(posedge clk);
        #1;
        chk({5'h0, wd, prl, ckr}, e);
        rd(0, 16'hFD00, c & 8'hEF, 1);
        rd(0, 16'hFD01, ~c, 1);
    endtask
    task automatic t_osc;
        for (int i = 0; i < 8; i++) begin
            boot({5'h1F, 3'(i)});
            chk({4'h0, ov, osc}, {4'h0, OSC_EXP[i]});
        end
    endtask
    // pin passes two sync flops and an output register
    task automatic t_pin(input logic [7:0] c, input logic [7:0] e);
        boot(c);
        @(posedge clk);
        pin <= 0;
        repeat (4) @(posedge clk);
        #1;
        chk({6'h0, prst, pinp}, e);
        @(posedge clk);
        pin <= 1;
    endtask
    // programming pins pass only while programming mode is up
    task automatic t_prog;
        @(posedge clk);
        psc <= 1;
        psd <= 1;
        repeat (4) @(posedge clk);
        #1;
        chk({6'h0, sclo, sdao}, 8'h00);
        @(posedge clk);
        pm <= 1;
        psd <= 0;
        repeat (4) @(posedge clk);
        #1;
        chk({6'h0, sclo, sdao}, 8'h02);
        @(posedge clk);
        psc <= 0;
        psd <= 1;
        repeat (4) @(posedge clk);
        #1;
        chk({6'h0, sclo, sdao}, 8'h01);
        @(posedge clk);
        pm <= 0;
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        t_reads;
        t_cfg(8'h57, 8'h00);
        t_cfg(8'hB8, 8'h07);
        t_osc;
        t_pin(8'h40, 8'h00);
        t_pin(8'h00, 8'h02);
        t_prog;
        end_of_test;
    end
endmodule
